// >>> common/pmc_pkg.sv
package pmc_pkg;

    // ----------------------------------------------------------------
    // Register map, word indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_CTRL = 8'h20;
    localparam logic [7:0] IDX_CHG = 8'h21;
    localparam logic [7:0] IDX_MODE0 = 8'h22;
    localparam logic [7:0] IDX_RSTMON = 8'h71;
    localparam int NUM_MODES = 4;
    localparam int NUM_RAILS = 4;
    localparam int VSEL_W = 5;

    // ----------------------------------------------------------------
    // Field layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [VSEL_W-1:0] v_d;
        logic [VSEL_W-1:0] v_c;
        logic [VSEL_W-1:0] v_b;
        logic [VSEL_W-1:0] v_a;
        logic key_return;
        logic pin_mode_ctrl;
        logic [1:0] watchdog;
        logic storage_req;
        logic [NUM_RAILS-1:0] rail_en;
    } pmc_mode_set_t;

    typedef struct packed {
        logic [1:0] long_press_time;
        logic thermistor_enable;
        logic sw_mode_bit_hi;
        logic sw_mode_bit_lo;
    } pmc_ctrl_t;

    typedef struct packed {
        logic [5:0] cv_code;
        logic [7:0] cc_code;
    } pmc_chg_t;

    typedef struct packed {
        logic key_level;
        logic [3:0] rsvd;
        logic reset_low;
        logic [1:0] active_mode;
    } pmc_rstmon_t;

    typedef struct packed {
        logic [NUM_RAILS-1:0] above_hi;
        logic [NUM_RAILS-1:0] above_lo;
    } pmc_rail_mon_t;

    typedef struct packed {
        logic hot;
        logic warm;
        logic cool;
        logic cold;
    } pmc_temp_zone_t;

    localparam int MODE_W = $bits(pmc_mode_set_t);
    localparam int CTRL_W = $bits(pmc_ctrl_t);
    localparam int CHG_W = $bits(pmc_chg_t);
    localparam int RSTMON_W = $bits(pmc_rstmon_t);

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam pmc_mode_set_t MODE_RST = '{5'h10, 5'h10, 5'h10, 5'h10, 1'b0, 1'b0, 2'h0, 1'b0, 4'hf};
    localparam pmc_ctrl_t CTRL_RST = '{2'h0, 1'b0, 1'b0, 1'b0};
    localparam pmc_chg_t CHG_RST = '{6'h20, 8'h40};

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int CLK_HZ = CLK_MHZ * 1000000;
    localparam int DEGLITCH_US = 200;
    localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
    localparam int LONG_UNIT_S = 4;
    localparam int LONG_UNIT_CYC = LONG_UNIT_S * CLK_HZ;
    localparam int CV_STEP_MV = 10;
    localparam int CV_HOT_OFFSET_MV = 140;
    localparam logic [5:0] CV_HOT_OFFSET = 6'(CV_HOT_OFFSET_MV / CV_STEP_MV);

    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_PWRUP,
        ST_ACTIVE,
        ST_SW_UP,
        ST_SW_DN,
        ST_PWRDN,
        ST_STORAGE
    } pmc_state_t;

endpackage

// >>> core/pmc_ctrl.sv
`timescale 1ns/1ps
module pmc_ctrl import pmc_pkg::*; #(
    parameter int DEGLITCH_CYC_P = DEGLITCH_CYC,
    parameter int LONG_UNIT_CYC_P = LONG_UNIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_key_n,
    input wire logic mode_pin_lo,
    input wire logic mode_pin_hi,
    input wire pmc_rail_mon_t rail_mon,
    input wire pmc_temp_zone_t temp_zone,
    output logic [NUM_RAILS-1:0] rail_enable,
    output logic [NUM_RAILS*VSEL_W-1:0] rail_vsel,
    output logic system_reset_out_n_o,
    output logic system_reset_out_n_oe,
    output logic charge_suspend,
    output logic [7:0] charge_current,
    output logic [5:0] charge_voltage
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    if (DEGLITCH_CYC_P < 2 || LONG_UNIT_CYC_P < 2 || longint'(LONG_UNIT_CYC_P) * 4 >= 64'h7fffffff) begin : g_chk
        $error("pmc_ctrl: timing parameters out of range");
    end

    localparam int DG_W = $clog2(DEGLITCH_CYC_P + 1);

    logic key_s, key_dn_s, mpin_hi_s, mpin_lo_s;
    pmc_rail_mon_t mon_s;
    pmc_temp_zone_t tz_s;
    logic [DG_W-1:0] dg_cnt_ff;
    logic [31:0] lp_cnt_ff, lp_limit;
    logic key_fall_ff, long_fire_ff, key_ok;
    pmc_mode_set_t mode_ff [NUM_MODES];
    pmc_ctrl_t ctrl_ff;
    pmc_chg_t chg_ff;
    pmc_state_t state_ff;
    logic [1:0] active_ff, target_ff, req_mode;
    logic ship_pend_ff, recycle_ff, regs_clr_ff;
    logic [NUM_RAILS-1:0] rail_en_ff, moving_ff, good;
    logic [NUM_RAILS*VSEL_W-1:0] vsel_ff, nxt_vsel;
    pmc_mode_set_t cur, tgt;
    logic pready_ff, pslverr_ff, wr_en, rd_hit, rst_oe_ff;
    logic [31:0] prdata_ff, rd_data;
    logic [7:0] idx;
    logic susp_ff;
    logic [7:0] cc_ff;
    logic [5:0] cv_ff;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    pmc_sync2 #(.W(3 + 2 * NUM_RAILS + 4)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({~power_key_n, mode_pin_hi, mode_pin_lo, rail_mon, temp_zone}),
        .q({key_dn_s, mpin_hi_s, mpin_lo_s, mon_s, tz_s})
    );

    // The key is synchronised inverted so that the flops reset to the released level.
    assign key_s = !key_dn_s;

    // ----------------------------------------------------------------
    // Power key deglitch and long press
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dg_cnt_ff <= '0;
            key_fall_ff <= 1'b0;
        end else if (key_s) begin
            dg_cnt_ff <= '0;
            key_fall_ff <= 1'b0;
        end else begin
            key_fall_ff <= (dg_cnt_ff == DG_W'(DEGLITCH_CYC_P - 1));
            if (dg_cnt_ff != DG_W'(DEGLITCH_CYC_P)) begin
                dg_cnt_ff <= dg_cnt_ff + 1'b1;
            end
        end
    end

    assign lp_limit = 32'((ctrl_ff.long_press_time + 3'h1) * LONG_UNIT_CYC_P);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_cnt_ff <= '0;
            long_fire_ff <= 1'b0;
        end else if (key_s) begin
            lp_cnt_ff <= '0;
            long_fire_ff <= 1'b0;
        end else begin
            long_fire_ff <= (lp_cnt_ff == lp_limit - 32'h1);
            if (lp_cnt_ff < lp_limit) begin
                lp_cnt_ff <= lp_cnt_ff + 32'h1;
            end
        end
    end

    assign key_ok = key_fall_ff && state_ff != ST_PWRUP && state_ff != ST_PWRDN;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign idx = paddr[9:2];
    assign wr_en = psel && penable && pwrite && pready_ff;

    always_comb begin
        rd_hit = 1'b1;
        rd_data = '0;
        if (paddr[ADDR_W-1:10] != '0 || paddr[1:0] != 2'h0) begin
            rd_hit = 1'b0;
        end else if (idx == IDX_CTRL) begin
            rd_data = 32'(ctrl_ff);
        end else if (idx == IDX_CHG) begin
            rd_data = 32'(chg_ff);
        end else if (idx >= IDX_MODE0 && idx < IDX_MODE0 + 8'(NUM_MODES)) begin
            rd_data = 32'(mode_ff[2'(idx - IDX_MODE0)]);
        end else if (idx == IDX_RSTMON) begin
            rd_data = 32'(pmc_rstmon_t'{key_s, 4'h0, rst_oe_ff, active_ff});
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= psel && !penable && !pready_ff;
            if (psel && !penable) begin
                pslverr_ff <= !rd_hit;
                prdata_ff <= pwrite ? 32'h0 : rd_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_MODES; i++) mode_ff[i] <= MODE_RST;
            ctrl_ff <= CTRL_RST;
            chg_ff <= CHG_RST;
        end else if (regs_clr_ff) begin
            for (int i = 0; i < NUM_MODES; i++) mode_ff[i] <= MODE_RST;
            ctrl_ff <= CTRL_RST;
            chg_ff <= CHG_RST;
        end else begin
            if (wr_en && paddr[1:0] == 2'h0 && paddr[ADDR_W-1:10] == '0) begin
                if (idx == IDX_CTRL) begin
                    ctrl_ff <= pmc_ctrl_t'(pwdata[CTRL_W-1:0]);
                end else if (idx == IDX_CHG) begin
                    chg_ff <= pmc_chg_t'(pwdata[CHG_W-1:0]);
                end else if (idx >= IDX_MODE0 && idx < IDX_MODE0 + 8'(NUM_MODES)) begin
                    mode_ff[2'(idx - IDX_MODE0)] <= pmc_mode_set_t'(pwdata[MODE_W-1:0]);
                end
            end
            if (key_ok) begin
                for (int i = 0; i < NUM_MODES; i++) mode_ff[i].pin_mode_ctrl <= 1'b0;
                if (cur.key_return) begin
                    ctrl_ff.sw_mode_bit_hi <= 1'b0;
                    ctrl_ff.sw_mode_bit_lo <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode selection and sequencer
    // ----------------------------------------------------------------
    assign cur = mode_ff[active_ff];
    assign tgt = mode_ff[target_ff];
    assign req_mode = cur.pin_mode_ctrl ? {mpin_hi_s, mpin_lo_s}
                                        : {ctrl_ff.sw_mode_bit_hi, ctrl_ff.sw_mode_bit_lo};

    always_comb begin
        nxt_vsel = vsel_ff;
        if (state_ff == ST_PWRUP || state_ff == ST_ACTIVE) begin
            nxt_vsel = {cur.v_d, cur.v_c, cur.v_b, cur.v_a};
        end else if (state_ff == ST_SW_UP || state_ff == ST_SW_DN) begin
            nxt_vsel = {tgt.v_d, tgt.v_c, tgt.v_b, tgt.v_a};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_STANDBY;
            active_ff <= 2'h0;
            target_ff <= 2'h0;
            ship_pend_ff <= 1'b0;
            recycle_ff <= 1'b0;
            regs_clr_ff <= 1'b0;
            rail_en_ff <= '0;
            vsel_ff <= '0;
        end else begin
            regs_clr_ff <= 1'b0;
            vsel_ff <= nxt_vsel;
            if (cur.storage_req && (state_ff == ST_ACTIVE || state_ff == ST_SW_UP || state_ff == ST_SW_DN)) begin
                state_ff <= ST_PWRDN;
                ship_pend_ff <= 1'b1;
            end else if (long_fire_ff && (state_ff == ST_ACTIVE || state_ff == ST_SW_UP || state_ff == ST_SW_DN)) begin
                state_ff <= ST_PWRDN;
                recycle_ff <= 1'b1;
            end else begin
                case (state_ff)
                    ST_STANDBY, ST_STORAGE: begin
                        rail_en_ff <= '0;
                        if (key_ok) begin
                            state_ff <= ST_PWRUP;
                            active_ff <= 2'h0;
                            target_ff <= 2'h0;
                        end
                    end
                    ST_PWRUP: begin
                        rail_en_ff <= cur.rail_en;
                        if (rail_en_ff == cur.rail_en && &(~cur.rail_en | mon_s.above_lo)) begin
                            state_ff <= ST_ACTIVE;
                        end
                    end
                    ST_ACTIVE: begin
                        rail_en_ff <= cur.rail_en;
                        if (key_ok && cur.key_return && active_ff != 2'h0) begin
                            target_ff <= 2'h0;
                            state_ff <= ST_SW_UP;
                        end else if (req_mode != active_ff) begin
                            target_ff <= req_mode;
                            state_ff <= ST_SW_UP;
                        end
                    end
                    ST_SW_UP: begin
                        rail_en_ff <= cur.rail_en | tgt.rail_en;
                        if (rail_en_ff == (cur.rail_en | tgt.rail_en) && &(~tgt.rail_en | mon_s.above_lo)) begin
                            state_ff <= ST_SW_DN;
                        end
                    end
                    ST_SW_DN: begin
                        rail_en_ff <= tgt.rail_en;
                        active_ff <= target_ff;
                        state_ff <= ST_ACTIVE;
                    end
                    ST_PWRDN: begin
                        rail_en_ff <= '0;
                        if (rail_en_ff == '0 && mon_s.above_lo == '0) begin
                            regs_clr_ff <= ship_pend_ff || recycle_ff;
                            active_ff <= 2'h0;
                            target_ff <= 2'h0;
                            ship_pend_ff <= 1'b0;
                            recycle_ff <= 1'b0;
                            state_ff <= ship_pend_ff ? ST_STORAGE : (recycle_ff ? ST_PWRUP : ST_STANDBY);
                        end
                    end
                    default: begin
                        state_ff <= ST_STANDBY;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // System reset
    // ----------------------------------------------------------------
    assign good = mon_s.above_lo & ~mon_s.above_hi;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            moving_ff <= '0;
        end else begin
            for (int i = 0; i < NUM_RAILS; i++) begin
                if (rail_en_ff[i] && nxt_vsel[i*VSEL_W +: VSEL_W] != vsel_ff[i*VSEL_W +: VSEL_W]) begin
                    moving_ff[i] <= 1'b1;
                end else if (good[i] || !rail_en_ff[i]) begin
                    moving_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_oe_ff <= 1'b1;
        end else begin
            rst_oe_ff <= |(rail_en_ff & ~moving_ff & ~good)
                || (state_ff == ST_PWRUP && !(&(~rail_en_ff | mon_s.above_lo)))
                || state_ff == ST_PWRDN || state_ff == ST_STANDBY || state_ff == ST_STORAGE;
        end
    end

    // ----------------------------------------------------------------
    // Charger temperature zoning
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            susp_ff <= 1'b0;
            cc_ff <= CHG_RST.cc_code;
            cv_ff <= CHG_RST.cv_code;
        end else begin
            susp_ff <= ctrl_ff.thermistor_enable && (tz_s.cold || tz_s.hot);
            cc_ff <= (ctrl_ff.thermistor_enable && tz_s.cool && !tz_s.cold) ? chg_ff.cc_code >> 1 : chg_ff.cc_code;
            if (ctrl_ff.thermistor_enable && tz_s.warm && !tz_s.hot) begin
                cv_ff <= (chg_ff.cv_code > CV_HOT_OFFSET) ? chg_ff.cv_code - CV_HOT_OFFSET : 6'h0;
            end else begin
                cv_ff <= chg_ff.cv_code;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign rail_enable = rail_en_ff;
    assign rail_vsel = vsel_ff;
    assign system_reset_out_n_o = 1'b0;
    assign system_reset_out_n_oe = rst_oe_ff;
    assign charge_suspend = susp_ff;
    assign charge_current = cc_ff;
    assign charge_voltage = cv_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_key_powerup: assert property (state_ff == ST_STANDBY && key_fall_ff |=> state_ff == ST_PWRUP)
        else $error("key edge did not start power-up");
    chk_storage_exit: assert property (state_ff == ST_STORAGE && key_fall_ff |=> state_ff == ST_PWRUP && active_ff == 2'h0)
        else $error("storage exit not into mode 0");
    chk_seq_ignore: assert property ((state_ff == ST_PWRUP || state_ff == ST_PWRDN) && key_fall_ff |=> $stable(target_ff))
        else $error("key edge acted during sequence");
    chk_pin_clear: assert property (key_ok && !regs_clr_ff && !wr_en |=> !mode_ff[active_ff].pin_mode_ctrl)
        else $error("pin mode control not cleared");
    chk_therm_susp: assert property (ctrl_ff.thermistor_enable && tz_s.hot && $stable(ctrl_ff) |=> charge_suspend)
        else $error("hot zone did not suspend charging");
    chk_cool_half: assert property (ctrl_ff.thermistor_enable && tz_s.cool && !tz_s.cold
        |=> charge_current == $past(chg_ff.cc_code) >> 1)
        else $error("cool zone current not halved");
    chk_ship_prio: assert property (state_ff == ST_ACTIVE && cur.storage_req |=> state_ff == ST_PWRDN ##1 rail_enable == '0)
        else $error("storage request did not power down");
    chk_switch_order: assert property (state_ff == ST_SW_UP ##1 state_ff == ST_SW_UP |-> (rail_enable & cur.rail_en) == cur.rail_en)
        else $error("old rail dropped before new rails up");
    chk_disabled_quiet: assert property (state_ff == ST_ACTIVE && (rail_en_ff & ~good) == '0 |=> !rst_oe_ff)
        else $error("reset asserted although every enabled rail is good");
    chk_deglitch_len: assert property (key_fall_ff |-> !$past(key_s) && !$past(key_s, 2))
        else $error("key edge without a held low level");

    cov_key_powerup: cover property (state_ff == ST_STANDBY ##1 state_ff == ST_PWRUP ##[1:1000] state_ff == ST_ACTIVE);
    cov_mode_switch: cover property (state_ff == ST_SW_UP ##[1:1000] state_ff == ST_SW_DN ##1 state_ff == ST_ACTIVE);
    cov_storage: cover property (ship_pend_ff ##[1:1000] state_ff == ST_STORAGE);
    cov_long_press: cover property (long_fire_ff && state_ff == ST_ACTIVE);

endmodule // pmc_ctrl

// >>> core/pmc_sync2.sv
`timescale 1ns/1ps
module pmc_sync2 import pmc_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // Two flops; the first one feeds only the second.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule // pmc_sync2

// >>> verif/pmc_mcu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Microcontroller and rail comparator model.
// ----------------------------------------------------------------
module pmc_mcu_model import pmc_pkg::*; (
    input wire logic pclk,
    input wire logic [NUM_RAILS-1:0] rail_enable,
    input wire logic [1:0] sel,
    input wire logic system_reset_out_n_oe,
    output pmc_rail_mon_t rail_mon,
    output logic mode_pin_lo,
    output logic mode_pin_hi,
    output logic mcu_reset_n
);
    always @(posedge pclk) begin
        rail_mon <= {{NUM_RAILS{1'b0}}, rail_enable};
    end
    assign {mode_pin_hi, mode_pin_lo} = sel;
    assign mcu_reset_n = system_reset_out_n_oe ? 1'b0 : 1'b1;
endmodule // pmc_mcu_model

// >>> verif/pmic_mode_and_reset_control_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench.
// ----------------------------------------------------------------
module pmic_mode_and_reset_control_test import pmc_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, key_n = 1, pready, pslverr, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [1:0] sel = '0;
    logic [3:0] rail_enable;
    logic [19:0] rail_vsel;
    logic oe, sro, suspend, mpl, mph, mcu_reset_n;
    logic [7:0] cur;
    logic [5:0] cv;
    pmc_rail_mon_t mon;
    pmc_temp_zone_t tz = '0;
    int fails = 0, cmp_count = 0;
    pmc_ctrl #(.DEGLITCH_CYC_P(8), .LONG_UNIT_CYC_P(50)) i_pmc_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_key_n(key_n), .mode_pin_lo(mpl), .mode_pin_hi(mph),
        .rail_mon(mon), .temp_zone(tz), .rail_enable(rail_enable), .rail_vsel(rail_vsel),
        .system_reset_out_n_o(sro), .system_reset_out_n_oe(oe), .charge_suspend(suspend),
        .charge_current(cur), .charge_voltage(cv));
    pmc_mcu_model i_pmc_mcu_model (.pclk(pclk), .rail_enable(rail_enable), .sel(sel),
        .system_reset_out_n_oe(oe), .rail_mon(mon), .mode_pin_lo(mpl), .mode_pin_hi(mph),
        .mcu_reset_n(mcu_reset_n));
    initial begin
        forever #25 pclk = ~pclk;
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wait_rails(input logic [3:0] e);
        for (int i = 0; i < 300 && rail_enable !== e; i++) @(posedge pclk);
    endtask
    task press();
        @(posedge pclk) key_n <= 0;
        repeat (14) @(posedge pclk);
        key_n <= 1;
    endtask
    task wait_up();
        for (int i = 0; i < 50 && oe !== 1'b0; i++) @(posedge pclk);
        chk("mcu_rst", mcu_reset_n, 1'b1);
    endtask
    task t_reset_powerup();
        chk("rails", rail_enable, 4'h0);
        chk("oe", oe, 1'b1);
        chk("cur", cur, 8'h40);
        @(posedge pclk) key_n <= 0;
        repeat (4) @(posedge pclk);
        key_n <= 1;
        repeat (20) @(posedge pclk);
        chk("rails", rail_enable, 4'h0);
        press();
        wait_rails(4'hf);
        chk("rails", rail_enable, 4'hf);
        wait_up();
        chk("vsel", rail_vsel, 20'h84210);
        chk("sro", sro, 1'b0);
        apb(0, 12'h1c4, 0);
        chk("rstmon", rd, 32'h80);
        chk("slverr", err, 1'b0);
    endtask
    task t_mode_switch();
        apb(1, 12'h08c, 32'h3);
        apb(1, 12'h080, 32'h1);
        wait_rails(4'h3);
        chk("rails", rail_enable, 4'h3);
        chk("mcu_rst", mcu_reset_n, 1'b1);
        apb(0, 12'h1c4, 0);
        chk("rstmon", rd, 32'h81);
        sel <= 2'h2;
        apb(1, 12'h090, 32'h8f);
        apb(1, 12'h08c, 32'h83);
        wait_rails(4'hf);
        repeat (8) @(posedge pclk);
        apb(0, 12'h1c4, 0);
        chk("rstmon", rd, 32'h82);
    endtask
    task t_key_pin_clear();
        press();
        repeat (40) @(posedge pclk);
        apb(0, 12'h08c, 0);
        chk("mode1", rd, 32'h3);
        apb(0, 12'h090, 0);
        chk("mode2", rd, 32'hf);
        apb(0, 12'h1c4, 0);
        chk("rstmon", rd, 32'h81);
        apb(0, 12'h3fc, 0);
        chk("slverr", err, 1'b1);
    endtask
    task t_charger();
        apb(1, 12'h080, 32'h5);
        tz <= 4'h2;
        repeat (8) @(posedge pclk);
        chk("cur", cur, 8'h20);
        chk("susp", suspend, 1'b0);
        tz <= 4'h4;
        repeat (8) @(posedge pclk);
        chk("cv", cv, 6'h12);
        tz <= 4'hc;
        repeat (8) @(posedge pclk);
        chk("susp", suspend, 1'b1);
        chk("cv", cv, 6'h20);
        tz <= 4'h3;
        repeat (8) @(posedge pclk);
        chk("susp", suspend, 1'b1);
        apb(1, 12'h080, 32'h1);
        repeat (8) @(posedge pclk);
        chk("susp", suspend, 1'b0);
        chk("cur", cur, 8'h40);
        tz <= 4'h0;
    endtask
    task t_long_press();
        key_n <= 0;
        wait_rails(4'h0);
        chk("rails", rail_enable, 4'h0);
        key_n <= 1;
        wait_rails(4'hf);
        chk("rails", rail_enable, 4'hf);
        wait_up();
        apb(0, 12'h08c, 0);
        chk("mode1", rd, 32'h1084200f);
    endtask
    task t_storage();
        apb(1, 12'h088, 32'h1084201f);
        wait_rails(4'h0);
        repeat (8) @(posedge pclk);
        chk("oe", oe, 1'b1);
        apb(0, 12'h088, 0);
        chk("mode0", rd, 32'h1084200f);
        press();
        wait_rails(4'hf);
        chk("rails", rail_enable, 4'hf);
        wait_up();
        apb(0, 12'h1c4, 0);
        chk("rstmon", rd, 32'h80);
    endtask
    task t_key_return();
        apb(1, 12'h08c, 32'h103);
        apb(1, 12'h080, 32'h1);
        wait_rails(4'h3);
        repeat (8) @(posedge pclk);
        press();
        wait_rails(4'hf);
        repeat (8) @(posedge pclk);
        apb(0, 12'h1c4, 0);
        chk("rstmon", rd, 32'h80);
        apb(0, 12'h080, 0);
        chk("ctrl", rd, 32'h0);
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #(50 * 6000);
        fails++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        t_reset_powerup();
        t_mode_switch();
        t_key_pin_clear();
        t_charger();
        t_long_press();
        t_storage();
        t_key_return();
        print_verdict();
    end
endmodule // pmic_mode_and_reset_control_test
